// *** src/fcb_host.sv ***
// Host controller for a parallel flash: takes orders over a register port and
// issues command sequences on the flash pins. Assumes the flash pins are async.
`timescale 1ns/1ps
`include "fcb_params.svh"

module fcb_host (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic [21:0] flash_addr_o,
    output logic chip_select_0_n_o,
    output logic chip_select_1_n_o,
    output logic output_enable_n_o,
    output logic write_strobe_n_o,
    output logic reset_powerdown_n_o,
    output logic width_select_n_o,
    output logic write_protect_n_o,
    output logic [15:0] dq_o,
    output logic dq_oe_n_o,
    input wire logic [15:0] dq_i,
    input wire logic busy_indicator_i
);
    fcb_pkg::fcb_seq_t state_r;
    fcb_pkg::fcb_op_t op_r;
    logic [2:0] ctrl_r;
    logic [7:0] code_r;
    logic [7:0] operand_r;
    logic [21:0] addr_r;
    logic [15:0] data_r;
    logic refused_r;
    logic issued_r;
    logic [5:0] recover_r;
    logic [4:0] fill_r;
    logic [3:0] ptr_r;
    logic [21:0] baddr_r;
    logic [21:0] buf_addr_mem [`FCB_BUF_DEPTH];
    logic [15:0] buf_data_mem [`FCB_BUF_DEPTH];
    logic [15:0] dq_meta_r;
    logic [15:0] dq_sync_r;
    logic busy_meta_r;
    logic busy_sync_r;
    logic pdown_d_r;
    logic cyc_start;
    logic cyc_write;
    logic [21:0] cyc_addr;
    logic [15:0] cyc_wdata;
    logic cyc_done;
    logic [15:0] cyc_rdata;
    logic cs_n;
    logic cmd_wr;
    logic cmd_ok;

    // Only codes of the defined set pass, except a read order, which passes with any code; everything else is refused
    function automatic logic legal_order(input logic [2:0] op, input logic [7:0] c, input logic [7:0] d);
        case (op)
            fcb_pkg::FCB_OP_CMD1: legal_order = c == `FCB_CMD_READ_ARRAY || c == `FCB_CMD_IDENT
                || c == `FCB_CMD_QUERY || c == `FCB_CMD_STATUS || c == `FCB_CMD_CLR_STATUS
                || c == `FCB_CMD_SUSPEND || c == `FCB_CMD_CONFIRM;
            fcb_pkg::FCB_OP_CMD2: legal_order = ((c == `FCB_CMD_BLK_ERASE || c == `FCB_CMD_CHIP_ERASE)
                && d == `FCB_CMD_CONFIRM) || c == `FCB_CMD_PROGRAM || c == `FCB_CMD_PROGRAM_ALT
                || (c == `FCB_CMD_LOCK && (d == `FCB_CMD_LOCK_SET || d == `FCB_CMD_CONFIRM))
                || (c == `FCB_CMD_IND_CFG && d <= `FCB_CMD_IND_MAX);
            fcb_pkg::FCB_OP_READ: legal_order = 1'b1;
            fcb_pkg::FCB_OP_BUF: legal_order = c == `FCB_CMD_BUF_PROGRAM;
            default: legal_order = 1'b0;
        endcase
    endfunction

    // ****************************************
    // Pin input synchronisers
    // ****************************************
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            dq_meta_r <= 16'h0000;
            dq_sync_r <= 16'h0000;
            busy_meta_r <= 1'b1;
            busy_sync_r <= 1'b1;
        end else begin
            dq_meta_r <= dq_i;
            dq_sync_r <= dq_meta_r;
            busy_meta_r <= busy_indicator_i;
            busy_sync_r <= busy_meta_r;
        end
    end

    // ****************************************
    // Register port
    // ****************************************
    assign cmd_wr = reg_wr_i && reg_addr_i == `FCB_REG_CMD;
    assign cmd_ok = legal_order(reg_wdata_i[2:0], reg_wdata_i[15:8], reg_wdata_i[23:16])
        && !(reg_wdata_i[2:0] == fcb_pkg::FCB_OP_BUF && fill_r == 5'h00);

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            ctrl_r <= `FCB_CTRL_RESET;
            addr_r <= 22'h00_0000;
            data_r <= 16'h0000;
            code_r <= `FCB_CMD_READ_ARRAY;
            operand_r <= 8'h00;
            op_r <= fcb_pkg::FCB_OP_CMD1;
            baddr_r <= 22'h00_0000;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `FCB_REG_CTRL: ctrl_r <= reg_wdata_i[2:0];
                `FCB_REG_ADDR: addr_r <= reg_wdata_i[21:0];
                `FCB_REG_DATA: data_r <= reg_wdata_i[15:0];
                `FCB_REG_BADDR: baddr_r <= reg_wdata_i[21:0];
                `FCB_REG_CMD: begin
                    if (state_r == fcb_pkg::FCB_SQ_IDLE && cmd_ok) begin
                        op_r <= fcb_pkg::fcb_op_t'(reg_wdata_i[2:0]);
                        code_r <= reg_wdata_i[15:8];
                        operand_r <= reg_wdata_i[23:16];
                    end
                end
                default: ;
            endcase
        end
    end

    // Write buffer for the buffered program sequence
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            fill_r <= 5'h00;
        end else if (reg_wr_i && reg_addr_i == `FCB_REG_BCLR) begin
            fill_r <= 5'h00;
        end else if (reg_wr_i && reg_addr_i == `FCB_REG_BDATA && fill_r != 5'(`FCB_BUF_DEPTH)) begin
            buf_addr_mem[fill_r[3:0]] <= baddr_r;
            buf_data_mem[fill_r[3:0]] <= reg_wdata_i[15:0];
            fill_r <= fill_r + 5'h01;
        end
    end

    // Sticky refusal flag; a new refusal wins over a clear in the same cycle
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            refused_r <= 1'b0;
        end else if (cmd_wr && (!cmd_ok || state_r != fcb_pkg::FCB_SQ_IDLE)) begin
            refused_r <= 1'b1;
        end else if (reg_wr_i && reg_addr_i == `FCB_REG_STAT && reg_wdata_i[`FCB_STAT_REFUSED]) begin
            refused_r <= 1'b0;
        end
    end

    // Read data stands in the cycle after the strobe only
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i || !reg_rd_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else begin
            case (reg_addr_i)
                `FCB_REG_CTRL: reg_rdata_o <= {29'h0000_0000, ctrl_r};
                `FCB_REG_CMD: reg_rdata_o <= {8'h00, operand_r, code_r, 5'h00, op_r};
                `FCB_REG_ADDR: reg_rdata_o <= {10'h000, addr_r};
                `FCB_REG_DATA: reg_rdata_o <= {16'h0000, data_r};
                `FCB_REG_STAT: reg_rdata_o <= {cyc_rdata, 13'h0000, refused_r, !busy_sync_r,
                    state_r != fcb_pkg::FCB_SQ_IDLE};
                `FCB_REG_BCLR: reg_rdata_o <= {27'h000_0000, fill_r};
                default: reg_rdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // Command sequencer
    // ****************************************
    // One engine cycle per sequencer step; issued_r blocks a second start
    assign cyc_start = state_r != fcb_pkg::FCB_SQ_IDLE && state_r != fcb_pkg::FCB_SQ_RECOVER && !issued_r;

    always_comb begin
        cyc_write = 1'b1;
        cyc_addr = addr_r;
        cyc_wdata = {8'h00, code_r};
        case (state_r)
            fcb_pkg::FCB_SQ_SECOND: cyc_wdata = op_r == fcb_pkg::FCB_OP_CMD2
                && (code_r == `FCB_CMD_PROGRAM || code_r == `FCB_CMD_PROGRAM_ALT) ? data_r : {8'h00, operand_r};
            fcb_pkg::FCB_SQ_COUNT: cyc_wdata = {11'h000, fill_r - 5'h01};
            fcb_pkg::FCB_SQ_PAIR: begin
                cyc_addr = buf_addr_mem[ptr_r];
                cyc_wdata = buf_data_mem[ptr_r];
            end
            fcb_pkg::FCB_SQ_CONFIRM: cyc_wdata = {8'h00, `FCB_CMD_CONFIRM};
            fcb_pkg::FCB_SQ_READ: cyc_write = 1'b0;
            default: ;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            state_r <= fcb_pkg::FCB_SQ_IDLE;
            issued_r <= 1'b0;
            ptr_r <= 4'h0;
            recover_r <= 6'h00;
            pdown_d_r <= 1'b0;
        end else begin
            pdown_d_r <= ctrl_r[`FCB_CTRL_PDOWN];
            if (cyc_start) begin
                issued_r <= 1'b1;
            end else if (cyc_done) begin
                issued_r <= 1'b0;
            end
            case (state_r)
                fcb_pkg::FCB_SQ_IDLE: begin
                    ptr_r <= 4'h0;
                    if (pdown_d_r && !ctrl_r[`FCB_CTRL_PDOWN]) begin
                        recover_r <= `FCB_PHWL_CYC;
                        state_r <= fcb_pkg::FCB_SQ_RECOVER;
                    end else if (cmd_wr && cmd_ok && !ctrl_r[`FCB_CTRL_PDOWN]) begin
                        state_r <= reg_wdata_i[2:0] == fcb_pkg::FCB_OP_READ ? fcb_pkg::FCB_SQ_READ
                            : fcb_pkg::FCB_SQ_FIRST;
                    end
                end
                fcb_pkg::FCB_SQ_FIRST: begin
                    if (cyc_done) begin
                        state_r <= op_r == fcb_pkg::FCB_OP_CMD2 ? fcb_pkg::FCB_SQ_SECOND
                            : op_r == fcb_pkg::FCB_OP_BUF ? fcb_pkg::FCB_SQ_COUNT : fcb_pkg::FCB_SQ_IDLE;
                    end
                end
                fcb_pkg::FCB_SQ_COUNT: begin
                    if (cyc_done) begin
                        state_r <= fcb_pkg::FCB_SQ_PAIR;
                    end
                end
                fcb_pkg::FCB_SQ_PAIR: begin
                    if (cyc_done) begin
                        ptr_r <= ptr_r + 4'h1;
                        if (5'(ptr_r) + 5'h01 == fill_r) begin
                            state_r <= fcb_pkg::FCB_SQ_CONFIRM;
                        end
                    end
                end
                fcb_pkg::FCB_SQ_RECOVER: begin
                    recover_r <= recover_r - 6'h01;
                    if (recover_r == 6'h01) begin
                        state_r <= fcb_pkg::FCB_SQ_IDLE;
                    end
                end
                default: begin
                    if (cyc_done) begin
                        state_r <= fcb_pkg::FCB_SQ_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Bus cycle engine and pins
    // ****************************************
    fcb_cycle u_cycle (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .start_i(cyc_start),
        .write_i(cyc_write),
        .byte_mode_i(ctrl_r[`FCB_CTRL_BYTE]),
        .addr_i(cyc_addr),
        .wdata_i(cyc_wdata),
        .dq_sync_i(dq_sync_r),
        .done_o(cyc_done),
        .rdata_o(cyc_rdata),
        .addr_o(flash_addr_o),
        .cs_n_o(cs_n),
        .oe_n_o(output_enable_n_o),
        .we_n_o(write_strobe_n_o),
        .dq_o(dq_o),
        .dq_oe_n_o(dq_oe_n_o)
    );

    // Both selects move together; the flash is in standby between cycles
    assign chip_select_0_n_o = cs_n;
    assign chip_select_1_n_o = cs_n;
    assign reset_powerdown_n_o = !ctrl_r[`FCB_CTRL_PDOWN];
    assign width_select_n_o = !ctrl_r[`FCB_CTRL_BYTE];
    assign write_protect_n_o = ctrl_r[`FCB_CTRL_WPN];

    sequence s_enter_confirm;
        state_r == fcb_pkg::FCB_SQ_PAIR && cyc_done && 5'(ptr_r) + 5'h01 == fill_r;
    endsequence

    sequence s_confirm_issue;
        ##1 state_r == fcb_pkg::FCB_SQ_CONFIRM && cyc_start && cyc_wdata[7:0] == `FCB_CMD_CONFIRM;
    endsequence

    chk_no_dual_strobe: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !(!output_enable_n_o && !write_strobe_n_o))
        else $error("output enable and write strobe low together");

    chk_refuse_bad_code: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        cmd_wr && !cmd_ok |=> refused_r && $stable(code_r) && $stable(op_r))
        else $error("undefined order not refused");

    chk_first_code_out: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        state_r == fcb_pkg::FCB_SQ_FIRST && cyc_start |-> ##1 (!dq_oe_n_o && !cs_n
            && dq_o[7:0] == code_r))
        else $error("first cycle did not carry the command code");

    chk_buf_confirm_last: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        s_enter_confirm |-> s_confirm_issue)
        else $error("confirm not issued after last pair");

    chk_buf_count_value: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        state_r == fcb_pkg::FCB_SQ_COUNT && cyc_start |=> dq_o[4:0] == fill_r - 5'h01)
        else $error("buffer count not N minus one");

    chk_recover_gap: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        $rose(reset_powerdown_n_o) |-> ##[1:3] state_r == fcb_pkg::FCB_SQ_RECOVER ##1 cs_n [*8])
        else $error("command written too soon after power-down release");
endmodule

// *** src/fcb_params.svh ***
// Constants for the parallel flash host controller: register map, command codes
// and bus timing. Assumes a 20 MHz system clock.
`ifndef FCB_PARAMS_SVH
`define FCB_PARAMS_SVH

// ****************************************
// Register map
// ****************************************
`define FCB_REG_CTRL 8'h00
`define FCB_REG_CMD 8'h04
`define FCB_REG_ADDR 8'h08
`define FCB_REG_DATA 8'h0C
`define FCB_REG_STAT 8'h10
`define FCB_REG_BADDR 8'h14
`define FCB_REG_BDATA 8'h18
`define FCB_REG_BCLR 8'h1C

// ****************************************
// Register fields and reset values
// ****************************************
`define FCB_CTRL_BYTE 0
`define FCB_CTRL_PDOWN 1
`define FCB_CTRL_WPN 2
`define FCB_CTRL_RESET 3'h4
`define FCB_STAT_REFUSED 2

// ****************************************
// Command codes on the flash data lines
// ****************************************
`define FCB_CMD_READ_ARRAY 8'hFF
`define FCB_CMD_IDENT 8'h90
`define FCB_CMD_QUERY 8'h98
`define FCB_CMD_STATUS 8'h70
`define FCB_CMD_CLR_STATUS 8'h50
`define FCB_CMD_BLK_ERASE 8'h20
`define FCB_CMD_CHIP_ERASE 8'h30
`define FCB_CMD_PROGRAM 8'h40
`define FCB_CMD_PROGRAM_ALT 8'h10
`define FCB_CMD_BUF_PROGRAM 8'hE8
`define FCB_CMD_SUSPEND 8'hB0
`define FCB_CMD_CONFIRM 8'hD0
`define FCB_CMD_LOCK 8'h60
`define FCB_CMD_LOCK_SET 8'h01
`define FCB_CMD_IND_CFG 8'hB8
`define FCB_CMD_IND_MAX 8'h03

// ****************************************
// Bus timing, figures in ns, counts in cycles
// ****************************************
`define FCB_CLK_NS 50
`define FCB_T_SETUP_NS 50
`define FCB_T_WP_NS 70
`define FCB_T_ACC_NS 120
`define FCB_T_HOLD_NS 50
`define FCB_T_PHWL_NS 1000
`define FCB_SETUP_CYC 4'((`FCB_T_SETUP_NS + `FCB_CLK_NS - 1) / `FCB_CLK_NS)
`define FCB_WP_CYC 4'((`FCB_T_WP_NS + `FCB_CLK_NS - 1) / `FCB_CLK_NS)
`define FCB_ACC_CYC 4'((`FCB_T_ACC_NS + `FCB_CLK_NS - 1) / `FCB_CLK_NS)
`define FCB_HOLD_CYC 4'((`FCB_T_HOLD_NS + `FCB_CLK_NS - 1) / `FCB_CLK_NS)
`define FCB_PHWL_CYC 6'((`FCB_T_PHWL_NS + `FCB_CLK_NS - 1) / `FCB_CLK_NS)
`define FCB_SYNC_CYC 4'h2
`define FCB_BUF_DEPTH 16

`endif

// *** src/fcb_pkg.sv ***
// Types for the parallel flash host controller.
// Assumes fcb_params.svh for all numeric constants.
package fcb_pkg;

    // Orders that software may give
    typedef enum logic [2:0] {
        FCB_OP_CMD1 = 3'b000,
        FCB_OP_CMD2 = 3'b001,
        FCB_OP_READ = 3'b010,
        FCB_OP_BUF = 3'b011
    } fcb_op_t;

    // Command sequencer states
    typedef enum logic [2:0] {
        FCB_SQ_IDLE = 3'b000,
        FCB_SQ_FIRST = 3'b001,
        FCB_SQ_SECOND = 3'b010,
        FCB_SQ_COUNT = 3'b011,
        FCB_SQ_PAIR = 3'b100,
        FCB_SQ_CONFIRM = 3'b101,
        FCB_SQ_READ = 3'b110,
        FCB_SQ_RECOVER = 3'b111
    } fcb_seq_t;

    // Single bus cycle states
    typedef enum logic [1:0] {
        FCB_CY_IDLE = 2'b00,
        FCB_CY_SETUP = 2'b01,
        FCB_CY_STROBE = 2'b10,
        FCB_CY_HOLD = 2'b11
    } fcb_cyc_t;

endpackage

// *** src/fcb_cycle.sv ***
// One flash bus cycle, read or write, with pin timing.
// Assumes dq_sync_i is already synchronised to clk_sys_i.
`timescale 1ns/1ps
`include "fcb_params.svh"

module fcb_cycle (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic start_i,
    input wire logic write_i,
    input wire logic byte_mode_i,
    input wire logic [21:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic [15:0] dq_sync_i,
    output logic done_o,
    output logic [15:0] rdata_o,
    output logic [21:0] addr_o,
    output logic cs_n_o,
    output logic oe_n_o,
    output logic we_n_o,
    output logic [15:0] dq_o,
    output logic dq_oe_n_o
);
    fcb_pkg::fcb_cyc_t state_r;
    logic write_r;
    logic [3:0] cnt_r;

    // ****************************************
    // Cycle sequencing
    // ****************************************
    // Strobe falls only after a full setup, so address is stable before it
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            state_r <= fcb_pkg::FCB_CY_IDLE;
            cnt_r <= 4'h0;
            write_r <= 1'b0;
        end else begin
            case (state_r)
                fcb_pkg::FCB_CY_IDLE: begin
                    if (start_i) begin
                        write_r <= write_i;
                        cnt_r <= `FCB_SETUP_CYC - 4'h1;
                        state_r <= fcb_pkg::FCB_CY_SETUP;
                    end
                end
                fcb_pkg::FCB_CY_SETUP: begin
                    if (cnt_r == 4'h0) begin
                        // Reads wait out access time plus the input synchroniser
                        cnt_r <= write_r ? `FCB_WP_CYC - 4'h1 : `FCB_ACC_CYC + `FCB_SYNC_CYC - 4'h1;
                        state_r <= fcb_pkg::FCB_CY_STROBE;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                fcb_pkg::FCB_CY_STROBE: begin
                    if (cnt_r == 4'h0) begin
                        cnt_r <= `FCB_HOLD_CYC - 4'h1;
                        state_r <= fcb_pkg::FCB_CY_HOLD;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                fcb_pkg::FCB_CY_HOLD: begin
                    if (cnt_r == 4'h0) begin
                        state_r <= fcb_pkg::FCB_CY_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                default: state_r <= fcb_pkg::FCB_CY_IDLE;
            endcase
        end
    end

    // ****************************************
    // Pin drive
    // ****************************************
    // Write strobe and output enable come from one state, never both low
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            cs_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            we_n_o <= 1'b1;
            dq_oe_n_o <= 1'b1;
            addr_o <= 22'h00_0000;
            dq_o <= 16'h0000;
        end else begin
            if (state_r == fcb_pkg::FCB_CY_IDLE && start_i) begin
                cs_n_o <= 1'b0;
                addr_o <= addr_i;
                dq_o <= byte_mode_i ? {8'h00, wdata_i[7:0]} : wdata_i;
                dq_oe_n_o <= !write_i;
            end
            if (state_r == fcb_pkg::FCB_CY_SETUP && cnt_r == 4'h0) begin
                we_n_o <= !write_r;
                oe_n_o <= write_r;
            end
            // Data stays driven through hold, past the rising write strobe
            if (state_r == fcb_pkg::FCB_CY_STROBE && cnt_r == 4'h0) begin
                we_n_o <= 1'b1;
                oe_n_o <= 1'b1;
            end
            if (state_r == fcb_pkg::FCB_CY_HOLD && cnt_r == 4'h0) begin
                cs_n_o <= 1'b1;
                dq_oe_n_o <= 1'b1;
            end
        end
    end

    // Read capture and completion pulse
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            rdata_o <= 16'h0000;
            done_o <= 1'b0;
        end else begin
            done_o <= state_r == fcb_pkg::FCB_CY_HOLD && cnt_r == 4'h0;
            if (state_r == fcb_pkg::FCB_CY_STROBE && cnt_r == 4'h0 && !write_r) begin
                // Byte mode carries data on the low eight lines only
                rdata_o <= byte_mode_i ? {8'h00, dq_sync_i[7:0]} : dq_sync_i;
            end
        end
    end

    // Write strobe is held low for the full pulse width
    chk_strobe_width: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        $fell(we_n_o) |-> !we_n_o[*2] ##1 we_n_o)
        else $error("write strobe width wrong");

    // Data lines driven whenever the write strobe is low
    chk_data_driven: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !we_n_o |-> !dq_oe_n_o && !cs_n_o ##1 !dq_oe_n_o)
        else $error("data not driven around write strobe");
endmodule

// *** tb/fcb_flash_model.sv ***
// Behavioural flash device facing the host controller.
// Assumes the host keeps its own strobe timing; address is not decoded.
`timescale 1ns/1ps
module fcb_flash_model (
    input wire logic cs_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic rp_n_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] dq_o,
    output logic busy_o,
    output logic [15:0] cmd_o
);
    logic [7:0] mode_r = 8'hFF;
    logic [15:0] val;
    initial busy_o = 1'b1;
    initial cmd_o = 16'h0000;
    // Latch on the strobe's rising edge while selected
    always @(posedge we_n_i) begin
        if (!cs_n_i && rp_n_i) begin
            cmd_o = wdata_i;
            if (wdata_i[7:0] != 8'hD0) mode_r = wdata_i[7:0];
            else busy_o <= #1000 1'b1;
            if (wdata_i[7:0] == 8'hD0) busy_o = 1'b0;
        end
    end
    // Wake-up lands in array read
    always @(posedge rp_n_i) mode_r = 8'hFF;
    // Undriven lines show the inverse, so stale data cannot pass
    assign val = (mode_r == 8'h70) ? 16'h0080 : 16'hA5C3;
    assign dq_o = (!cs_n_i && !oe_n_i && we_n_i && rp_n_i) ? val : ~val;
endmodule

// *** tb/tb_fcb_host.sv ***
// Self-checking bench for the flash host controller.
// Assumes the flash model answers reads and records writes.
`timescale 1ns/1ps
`include "fcb_params.svh"
module tb_fcb_host;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0000_0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o, rd_r;
    logic [21:0] flash_addr_o;
    logic cs0, cs1, oe_n, we_n, rp_n, wsel_n, wp_n, dq_oe_n, busy;
    logic [15:0] dq_o, dq_i, cmd_w;
    int n_errors = 0;
    int comparisons = 0;
    logic [7:0] codes [7] = '{8'hFF, 8'h90, 8'h98, 8'h70, 8'h50, 8'hB0, 8'hD0};
    initial forever #25 clk_sys_i = ~clk_sys_i;
    fcb_host uut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .flash_addr_o(flash_addr_o), .chip_select_0_n_o(cs0), .chip_select_1_n_o(cs1),
        .output_enable_n_o(oe_n), .write_strobe_n_o(we_n), .reset_powerdown_n_o(rp_n),
        .width_select_n_o(wsel_n), .write_protect_n_o(wp_n), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n),
        .dq_i(dq_i), .busy_indicator_i(busy));
    fcb_flash_model flash (.cs_n_i(cs0 | cs1), .oe_n_i(oe_n), .we_n_i(we_n), .rp_n_i(rp_n),
        .wdata_i(dq_o), .dq_o(dq_i), .busy_o(busy), .cmd_o(cmd_w));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 rd_r = reg_rdata_o;
    endtask
    // Issue one order and poll the busy bit with a bound
    task automatic cmd(input logic [2:0] op, input logic [7:0] c, input logic [7:0] opd);
        wr(`FCB_REG_CMD, {8'h00, opd, c, 5'h00, op});
        repeat (2) @(posedge clk_sys_i);
        for (int i = 0; i < 100; i++) begin
            rd(`FCB_REG_STAT);
            if (rd_r[0] === 1'b0) break;
        end
        chk({31'h0000_0000, rd_r[0]}, 32'h0000_0000);
    endtask
    task automatic finish_test;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_errors++;
        finish_test;
    end
    // Reset values seen on the register port and the power-down pin
    task automatic t_reset_state;
        rd(`FCB_REG_CTRL);
        chk(rd_r, 32'h0000_0004);
        chk({31'h0000_0000, rp_n}, 32'h0000_0001);
    endtask
    // Every single-cycle code reaches the data lines, then the bus idles
    task automatic t_single;
        foreach (codes[i]) begin
            cmd(3'h0, codes[i], 8'h00);
            chk({16'h0000, cmd_w}, {24'h00_0000, codes[i]});
        end
        chk({27'h000_0000, cs0, cs1, oe_n, we_n, dq_oe_n}, 32'h0000_001F);
    endtask
    // Two-cycle orders, each ending on a code unlike the one before
    task automatic t_two_cycle;
        cmd(3'h1, 8'h60, 8'h01);
        chk({16'h0000, cmd_w}, 32'h0000_0001);
        cmd(3'h1, 8'h20, 8'hD0);
        chk({16'h0000, cmd_w}, 32'h0000_00D0);
        for (int k = 0; k < 4; k++) begin
            cmd(3'h1, 8'hB8, 8'(k));
            chk({16'h0000, cmd_w}, 32'(k));
        end
        cmd(3'h1, 8'h60, 8'hD0);
        chk({16'h0000, cmd_w}, 32'h0000_00D0);
        chk({31'h0000_0000, wp_n}, 32'h0000_0001);
    endtask
    // Program with either setup code sends the data word at the address register
    task automatic t_program;
        wr(`FCB_REG_ADDR, 32'h0015_A5A5);
        wr(`FCB_REG_DATA, 32'h0000_1234);
        cmd(3'h1, 8'h40, 8'h00);
        chk({16'h0000, cmd_w}, 32'h0000_1234);
        chk({10'h000, flash_addr_o}, 32'h0015_A5A5);
        wr(`FCB_REG_DATA, 32'h0000_5678);
        cmd(3'h1, 8'h10, 8'h00);
        chk({16'h0000, cmd_w}, 32'h0000_5678);
        // Busy pin still low from the confirm when the poll ends
        cmd(3'h1, 8'h30, 8'hD0);
        chk({16'h0000, cmd_w}, 32'h0000_00D0);
        chk({31'h0000_0000, rd_r[1]}, 32'h0000_0001);
    endtask
    // Bad second code is refused and never sent
    task automatic t_refuse;
        cmd(3'h1, 8'h20, 8'h55);
        chk({16'h0000, cmd_w}, 32'h0000_00D0);
        chk({31'h0000_0000, rd_r[2]}, 32'h0000_0001);
    endtask
    // Status mode reads back the status value
    task automatic t_status;
        cmd(3'h0, 8'h70, 8'h00);
        cmd(3'h2, 8'h00, 8'h00);
        chk({16'h0000, rd_r[31:16]}, 32'h0000_0080);
    endtask
    // Buffered program: refused when empty, then two pairs and the confirm
    task automatic t_buffer;
        wr(`FCB_REG_STAT, 32'h0000_0004);
        rd(`FCB_REG_STAT);
        chk({31'h0000_0000, rd_r[2]}, 32'h0000_0000);
        wr(`FCB_REG_BCLR, 32'h0000_0000);
        cmd(3'h3, 8'hE8, 8'h00);
        chk({31'h0000_0000, rd_r[2]}, 32'h0000_0001);
        wr(`FCB_REG_BADDR, 32'h0000_0100);
        wr(`FCB_REG_BDATA, 32'h0000_BEEF);
        wr(`FCB_REG_BADDR, 32'h0000_0101);
        wr(`FCB_REG_BDATA, 32'h0000_CAFE);
        rd(`FCB_REG_BCLR);
        chk(rd_r, 32'h0000_0002);
        cmd(3'h3, 8'hE8, 8'h00);
        chk({16'h0000, cmd_w}, 32'h0000_00D0);
        chk({10'h000, flash_addr_o}, 32'h0015_A5A5);
    endtask
    // Byte mode: width pin low, code on the low lines
    task automatic t_byte;
        wr(`FCB_REG_CTRL, 32'h0000_0005);
        cmd(3'h0, 8'hFF, 8'h00);
        chk({31'h0000_0000, wsel_n}, 32'h0000_0000);
        chk({16'h0000, cmd_w}, 32'h0000_00FF);
    endtask
    // Power-down from status mode; after the quiet time the array reads again
    task automatic t_power;
        cmd(3'h0, 8'h70, 8'h00);
        wr(`FCB_REG_CTRL, 32'h0000_0006);
        repeat (2) @(posedge clk_sys_i);
        chk({31'h0000_0000, rp_n}, 32'h0000_0000);
        wr(`FCB_REG_CTRL, 32'h0000_0004);
        repeat (25) @(posedge clk_sys_i);
        cmd(3'h2, 8'h00, 8'h00);
        chk({16'h0000, rd_r[31:16]}, 32'h0000_A5C3);
    endtask
    // Scenario order matters: t_refuse expects the code t_program left behind, and t_buffer its address
    initial begin
        repeat (12) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        t_reset_state;
        t_single;
        t_two_cycle;
        t_program;
        t_refuse;
        t_status;
        t_buffer;
        t_byte;
        t_power;
        finish_test;
    end
endmodule
